// >>> verilog/rx_queue_pkg.sv
`default_nettype none
package rx_queue_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_SETUP = 12'h000;
	localparam logic [11:0] OFS_CONFIG = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h010;
	localparam logic [11:0] OFS_IRQ_CLEAR = 12'h014;
	// rx_queue_config fields
	localparam int FLUSH_BIT = 7;
	localparam int CMP_SEL_BIT = 6;
	localparam int THR_LSB = 0;
	// queue_setup fields
	localparam int ENABLE_BIT = 0;
	localparam int DUPLEX_LSB = 1;
	// duplex modes in queue_setup[2:1]
	localparam logic [1:0] DPX_HALF_RX = 2'h0;
	localparam logic [1:0] DPX_HALF_TX = 2'h1;
	localparam logic [1:0] DPX_FULL = 2'h2;
	// queue sizes
	localparam logic [2:0] SIZE_HALF = 3'h4;
	localparam logic [2:0] SIZE_FULL = 3'h2;
	// threshold codes
	localparam logic [1:0] THR_CODE_MAX = 2'h0;
	localparam logic [1:0] THR_CODE_ONE = 2'h1;
	localparam logic [1:0] THR_CODE_MID = 2'h3;
	localparam logic [2:0] THR_HALF_MAX = 3'h4;
	localparam logic [2:0] THR_FULL_MAX = 3'h2;
	localparam logic [2:0] THR_ONE = 3'h1;
	localparam logic [2:0] THR_HALF_MID = 3'h3;
	// irq status bits
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_OVF_BIT = 1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : rx_queue_pkg
`default_nettype wire

// >>> verilog/serial_rx_fifo_config.sv
// Contract
// (R01) transmit queue always offers full configured depth; tx_capacity here is 0 when disabled or in DPX_HALF_RX
// (R02) software avoids queues in 9-bit mode
// (R03) flush empties queue, count zero, reads zero
// (R04) compare select: equal or at-least threshold
// (R05) threshold code decodes by duplex mode
// (R06) software: duplex, enable, then flush
// (R07) queue sizes follow duplex when enabled
// (R08) unused bits read zero, fields reset zero
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module serial_rx_fifo_config (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic rx_push, // received byte strobe
	input wire logic [7:0] rx_byte, // received byte
	input wire logic rx_pop, // consumer pop strobe
	output logic [7:0] rx_head, // byte at read pointer
	output logic rx_nonempty, // queue holds data
	output logic [2:0] tx_capacity, // usable transmit depth
	output logic rx_irq_cond, // threshold condition
	output logic irq // interrupt level
);
	// whole block state in one struct
	// queue store is four byte flops, indexed by the pointers
	typedef struct packed {
		logic [7:0] mem0;
		logic [7:0] mem1;
		logic [7:0] mem2;
		logic [7:0] mem3;
		logic [1:0] rd_ptr;
		logic [1:0] wr_ptr;
		logic [2:0] count;
		logic queue_enable;
		logic [1:0] duplex;
		logic cmp_sel;
		logic [1:0] thr;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic cond_prev;
		logic [31:0] rdata;
		logic err;
		// high in the second access cycle; read data is a flop by then
		logic ack;
	} state_t;
	state_t s_q, s_d;
	logic [2:0] depth;
	logic [2:0] level;
	logic cond;
	logic acc_first;
	logic wr_acc;
	logic rd_acc;
	logic do_push;
	logic do_pop;
	////////////////////////////////////////////////////////////////
	function automatic logic [2:0] decode_thr(input logic [1:0] code, input logic full);
		logic [2:0] v;
		v = rx_queue_pkg::THR_ONE;
		case (code)
			rx_queue_pkg::THR_CODE_MAX: v = full ? rx_queue_pkg::THR_FULL_MAX
				: rx_queue_pkg::THR_HALF_MAX; // [R05]
			rx_queue_pkg::THR_CODE_ONE: v = rx_queue_pkg::THR_ONE; // [R05]
			rx_queue_pkg::THR_CODE_MID: v = full ? rx_queue_pkg::THR_ONE
				: rx_queue_pkg::THR_HALF_MID; // [R05]
			// code 10 undefined: treated as one byte
			default: v = rx_queue_pkg::THR_ONE;
		endcase
		return v;
	endfunction : decode_thr
	function automatic logic [1:0] ptr_next(input logic [1:0] p, input logic [2:0] d);
		return ({1'b0, p} + 3'h1 >= d) ? 2'h0 : p + 2'h1;
	endfunction : ptr_next
	function automatic logic is_full(input logic [1:0] dpx);
		return dpx == rx_queue_pkg::DPX_FULL;
	endfunction : is_full
	// full duplex halves both queues; half duplex gives 4 bytes to rx, and to tx unless DPX_HALF_RX
	function automatic logic [2:0] queue_depth(input logic [1:0] dpx);
		logic [2:0] n;
		n = rx_queue_pkg::SIZE_HALF;
		if (is_full(dpx))
			n = rx_queue_pkg::SIZE_FULL;
		return n;
	endfunction : queue_depth
	// one decoder for both directions keeps the error map consistent
	function automatic logic addr_mapped(input logic [11:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			rx_queue_pkg::OFS_SETUP,
			rx_queue_pkg::OFS_CONFIG,
			rx_queue_pkg::OFS_STATUS,
			rx_queue_pkg::OFS_IRQ_STATUS,
			rx_queue_pkg::OFS_IRQ_ENABLE,
			rx_queue_pkg::OFS_IRQ_CLEAR: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : addr_mapped
	////////////////////////////////////////////////////////////////
	always_comb
	begin
		depth = queue_depth(s_q.duplex); // [R07]
		// tx depth is never cut by receive threshold settings
		tx_capacity = !s_q.queue_enable ? 3'h0 :
			(s_q.duplex == rx_queue_pkg::DPX_HALF_RX) ? 3'h0 : depth; // [R01] [R07]
		level = decode_thr(s_q.thr, is_full(s_q.duplex));
		cond = s_q.queue_enable && (s_q.cmp_sel ? (s_q.count >= level)
			: (s_q.count == level)); // [R04]
		// first access cycle loads read data, second one answers and commits
		acc_first = psel && penable && !s_q.ack;
		wr_acc = psel && penable && pwrite && s_q.ack;
		rd_acc = acc_first && !pwrite;
		do_push = rx_push && s_q.queue_enable && (s_q.count < depth);
		do_pop = rx_pop && (s_q.count != 3'h0);
		s_d = s_q;
		s_d.err = 1'b0;
		s_d.ack = acc_first;
		// error flop lines up with pready for writes and reads alike
		if (acc_first && !addr_mapped(paddr))
			s_d.err = 1'b1;
		s_d.cond_prev = cond;
		if (do_push)
		begin
			case (s_q.wr_ptr)
				2'h0: s_d.mem0 = rx_byte;
				2'h1: s_d.mem1 = rx_byte;
				2'h2: s_d.mem2 = rx_byte;
				default: s_d.mem3 = rx_byte;
			endcase
			s_d.wr_ptr = ptr_next(s_q.wr_ptr, depth);
		end
		if (do_pop)
			s_d.rd_ptr = ptr_next(s_q.rd_ptr, depth);
		s_d.count = s_q.count + (do_push ? 3'h1 : 3'h0) - (do_pop ? 3'h1 : 3'h0);
		// rising condition edge is the interrupt event; set wins over clear
		if (rx_push && s_q.queue_enable && !do_push)
			s_d.irq_status[rx_queue_pkg::IRQ_OVF_BIT] = 1'b1;
		s_d.rdata = 32'h00000000;
		if (rd_acc)
		begin
			case (paddr)
				rx_queue_pkg::OFS_SETUP: s_d.rdata = {29'h0, s_q.duplex, s_q.queue_enable};
				// flush bit and bits 5..2 read zero
				rx_queue_pkg::OFS_CONFIG: s_d.rdata = {24'h0, 1'b0, s_q.cmp_sel,
					4'h0, s_q.thr}; // [R03] [R08]
				rx_queue_pkg::OFS_STATUS: s_d.rdata = {29'h0, s_q.count};
				rx_queue_pkg::OFS_IRQ_STATUS: s_d.rdata = {30'h0, s_q.irq_status};
				rx_queue_pkg::OFS_IRQ_ENABLE: s_d.rdata = {30'h0, s_q.irq_enable};
				rx_queue_pkg::OFS_IRQ_CLEAR: s_d.rdata = 32'h00000000;
				default: s_d.err = 1'b1;
			endcase
		end
		if (wr_acc)
		begin
			case (paddr)
				rx_queue_pkg::OFS_SETUP:
				begin
					s_d.queue_enable = pwdata[rx_queue_pkg::ENABLE_BIT];
					s_d.duplex = pwdata[rx_queue_pkg::DUPLEX_LSB +: 2];
				end
				rx_queue_pkg::OFS_CONFIG:
				begin
					s_d.cmp_sel = pwdata[rx_queue_pkg::CMP_SEL_BIT]; // [R08]
					s_d.thr = pwdata[rx_queue_pkg::THR_LSB +: 2];
					if (pwdata[rx_queue_pkg::FLUSH_BIT])
					begin
						// flush overrides a push in the same cycle
						s_d.count = 3'h0; // [R03]
						s_d.rd_ptr = 2'h0; // [R03]
						s_d.wr_ptr = 2'h0; // [R03]
					end
				end
				rx_queue_pkg::OFS_IRQ_ENABLE: s_d.irq_enable = pwdata[1:0];
				rx_queue_pkg::OFS_IRQ_CLEAR: s_d.irq_status = s_q.irq_status & ~pwdata[1:0];
				rx_queue_pkg::OFS_STATUS, rx_queue_pkg::OFS_IRQ_STATUS: ;
				// unmapped writes already flagged in the first access cycle
				default: ;
			endcase
		end
		if (cond && !s_q.cond_prev)
			s_d.irq_status[rx_queue_pkg::IRQ_RX_BIT] = 1'b1;
		if (rx_push && s_q.queue_enable && !do_push)
			s_d.irq_status[rx_queue_pkg::IRQ_OVF_BIT] = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0; // [R08]
		else
			s_q <= s_d;
	end
	always_comb
	begin
		case (s_q.rd_ptr)
			2'h0: rx_head = s_q.mem0;
			2'h1: rx_head = s_q.mem1;
			2'h2: rx_head = s_q.mem2;
			default: rx_head = s_q.mem3;
		endcase
	end
	// one wait state: read data comes from a flip-flop
	// costs a cycle per access, but keeps prdata glitch free
	assign pready = s_q.ack;
	assign prdata = s_q.rdata;
	assign pslverr = s_q.err;
	assign rx_nonempty = s_q.count != 3'h0;
	assign rx_irq_cond = s_q.cond_prev;
	assign irq = |(s_q.irq_status & s_q.irq_enable);
endmodule : serial_rx_fifo_config
`default_nettype wire

// >>> dv/rx_queue_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rx_queue_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // write
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // ready
	input wire logic rx_nonempty, // data held
	input wire logic [2:0] tx_capacity, // tx depth
	input wire logic rx_irq_cond // condition
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic cfg, fl, sw;
	assign cfg = psel && penable && pready && paddr == rx_queue_pkg::OFS_CONFIG;
	assign fl = cfg && pwrite && pwdata[7];
	assign sw = psel && penable && pready && pwrite && paddr == rx_queue_pkg::OFS_SETUP;
	////////////////////////////////
	a_flush_empties: assert property (fl |=> !rx_nonempty) else $error("data after flush");
	// condition lags the flopped count by one more edge
	a_flush_drops_cond:
		assert property (fl |=> ##1 !rx_irq_cond) else $error("condition after flush");
	a_cfg_unused_zero:
		assert property (cfg && !pwrite |-> !prdata[31:7] && !prdata[5:2]) else $error("bits set");
	a_tx_full_depth: assert property (sw && pwdata[2:0] == 3'h5 |=> tx_capacity == 3'h2)
		else $error("full duplex depth");
	a_tx_half_depth: assert property (sw && pwdata[2:0] == 3'h3 |=> tx_capacity == 3'h4)
		else $error("half duplex depth");
	a_tx_depth_held: assert property (!sw |=> $stable(tx_capacity)) else $error("depth moved");
	c_flush: cover property (fl);
	c_cond: cover property ($rose(rx_irq_cond));
	c_tx: cover property (sw ##1 tx_capacity == 3'h4);
	c_drain: cover property ($fell(rx_nonempty) && !fl);
endmodule : rx_queue_checker
bind serial_rx_fifo_config rx_queue_checker rx_queue_checker_inst (.*);
`default_nettype wire

// >>> dv/test_serial_rx_fifo_config.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_rx_fifo_config;
	logic pclk, presetn, psel, penable, pwrite, rx_push, rx_pop, pready, pslverr, e;
	logic rx_nonempty, rx_irq_cond, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [7:0] rx_byte, rx_head, b;
	logic [2:0] tx_capacity;
	int n_mismatch, n_compared, t;
	serial_rx_fifo_config serial_rx_fifo_config_inst (.*);
	////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// sample mid-cycle: values stand until the next rising edge
		do
		begin
			@(negedge pclk);
			rdy = pready;
			r = prdata;
			e = pslverr;
			@(posedge pclk);
		end
		while (rdy !== 1'h1);
		{psel, penable} <= 2'h0;
		#1;
	endtask : apb
	task automatic pop();
		rx_pop <= 1'h1;
		@(posedge pclk);
		rx_pop <= 1'h0;
		#1;
	endtask : pop
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
			begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic psh(input logic [7:0] d);
		rx_push <= 1'h1;
		rx_byte <= d;
		@(posedge pclk);
		rx_push <= 1'h0;
		@(posedge pclk);
		#1;
	endtask : psh
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	function automatic int thr(input int dp, input logic [1:0] c);
		if (c == 2'h0) return (dp == 2) ? 2 : 4;
		if (c == 2'h3) return (dp == 2) ? 1 : 3;
		return 1;
	endfunction : thr
	////////////////////////////////
	initial
	begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		#400000;
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, rx_push, rx_pop, paddr, pwdata, rx_byte} = '0;
		void'($urandom(30));
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, rx_queue_pkg::OFS_CONFIG, 32'h0);
		chk(r, 32'h0);
		for (int dp = 0; dp < 3; dp++)
		begin
			// duplex and enable first, flush after; never 9-bit mode
			apb(1'h1, rx_queue_pkg::OFS_SETUP, 32'(dp * 2 + 1));
			for (int c = 0; c < 8; c++)
			begin
				v = $urandom;
				v[7:6] = {1'h1, c[2]};
				v[1:0] = c[1:0];
				apb(1'h1, rx_queue_pkg::OFS_CONFIG, v);
				apb(1'h0, rx_queue_pkg::OFS_CONFIG, 32'h0);
				chk(r, v & 32'h43);
				apb(1'h0, rx_queue_pkg::OFS_STATUS, 32'h0);
				chk(r, 32'h0);
				chk(tx_capacity, dp == 1 ? 4 : dp == 2 ? 2 : 0);
				t = thr(dp, c[1:0]);
				for (int n = 1; n <= (dp == 2 ? 2 : 4); n++)
				begin
					b = $urandom;
					psh(b);
					if (n == 1) chk(rx_head, b);
					chk(rx_irq_cond, c[2] ? n >= t : n == t);
				end
			end
			$display("test duplex %0d done", dp);
		end
		apb(1'h1, rx_queue_pkg::OFS_CONFIG, 32'h81);
		apb(1'h1, rx_queue_pkg::OFS_IRQ_CLEAR, 32'h3);
		apb(1'h1, rx_queue_pkg::OFS_IRQ_ENABLE, 32'h1);
		chk(irq, 1'h0);
		psh(8'h5A);
		repeat (2) @(posedge pclk);
		#1;
		chk(irq, 1'h1);
		apb(1'h1, rx_queue_pkg::OFS_IRQ_ENABLE, 32'h0);
		chk(irq, 1'h0);
		apb(1'h1, rx_queue_pkg::OFS_IRQ_CLEAR, 32'h1);
		apb(1'h1, rx_queue_pkg::OFS_IRQ_ENABLE, 32'h1);
		chk(irq, 1'h0);
		apb(1'h0, 12'hFF0, 32'h0);
		chk(e, 1'h1);
		psh(8'hC3);
		pop();
		chk(rx_head, 8'hC3);
		chk(rx_nonempty, 1'h1);
		pop();
		chk(rx_nonempty, 1'h0);
		$display("test irq done");
		finish_test();
	end
endmodule : test_serial_rx_fifo_config
`default_nettype wire
